// File: bench/dsmc_src_model.sv
/* dsmc_src_model: far-side set-point sources, samples and step pins.
   Assumes its tasks are called just after a rising clock edge. */
`timescale 1ns/100ps
`default_nettype none
module dsmc_src_model (
    // clock
    input  wire logic clk,
    // samples and pins
    output logic [15:0] analog_input_one,
    output logic [15:0] analog_input_two,
    output logic [15:0] pwm_duty,
    output logic        digital_input_one,
    output logic        digital_input_two,
    output logic        renc_a,
    output logic        renc_b
);
    // quadrature inputs stay idle, pulse/direction owns the port
    initial begin
        {analog_input_one, analog_input_two, pwm_duty} = 48'h0;
        {digital_input_one, digital_input_two, renc_a, renc_b} = 4'h0;
    end
    task automatic set_src(input logic [15:0] a1, input logic [15:0] pw);
        @(posedge clk);
        analog_input_one <= a1;
        analog_input_two <= ~a1;
        pwm_duty <= pw;
    endtask
    // slow pulses so the three-flop synchroniser sees each one
    task automatic pulses(input int n, input logic down);
        digital_input_two <= down;
        repeat (n) begin
            repeat (4) @(posedge clk);
            digital_input_one <= 1'b1;
            repeat (4) @(posedge clk);
            digital_input_one <= 1'b0;
        end
    endtask
endmodule
`default_nettype wire

// File: bench/dsmc_top_bench.sv
/* dsmc_top_bench: self-checking bench of dsmc_top.
   Assumes the source model in dsmc_src_model and a 100 ns clock. */
`timescale 1ns/100ps
`default_nettype none
module dsmc_top_bench import dsmc_pkg::*; ;
logic clk = 1'b0, rst_n = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
logic [7:0] wb_adr_i = 8'h00;
logic [3:0] wb_sel_i = 4'hf;
logic [31:0] wb_dat_i = 32'h0, abs_enc_pos = 32'h0, actual_pos = 32'h0, q, wb_dat_o, ctl_setpoint;
logic [15:0] actual_rpm = 16'h0, analog_input_one, analog_input_two, pwm_duty;
logic menc_a = 1'b0, menc_b = 1'b0, lim_pos_sw = 1'b0, lim_neg_sw = 1'b0;
logic digital_input_one, digital_input_two, renc_a, renc_b, wb_ack_o, ctl_update, stage_active, irq;
logic [2:0] ctl_mode;
int bad_count = 0, total_checks = 0;
dsmc_top i_dsmc_top (.clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .analog_input_one, .analog_input_two, .pwm_duty,
    .abs_enc_pos, .menc_a, .menc_b, .renc_a, .renc_b, .digital_input_one,
    .digital_input_two, .lim_pos_sw, .lim_neg_sw, .actual_pos, .actual_rpm,
    .ctl_setpoint, .ctl_mode, .ctl_update, .stage_active, .irq);
dsmc_src_model i_dsmc_src_model (.clk, .analog_input_one, .analog_input_two, .pwm_duty,
    .digital_input_one, .digital_input_two, .renc_a, .renc_b);
always #50 clk = ~clk;
task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
        bad_count++;
        $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
endtask
task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
    @(posedge clk);
    // no local limit: the watchdog ends a hung bus
    while (wb_ack_o !== 1'b1) @(posedge clk);
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
endtask
// waits out k control cycles, judged one edge after the update's own edge
task automatic wup(input int k);
    repeat (k) begin
        @(posedge clk);
        while (ctl_update !== 1'b1) @(posedge clk);
    end
endtask
task automatic t_regs;
    wb(0, DSMC_ADR_MODE, 0);
    chk(q, {24'h0, DSMC_RST_MODE});
    wb(1, 8'h3c, 32'hffff_ffff);
    wb(0, 8'h3c, 0);
    chk(q, 32'h0);
    wb(1, DSMC_ADR_OPTS, 32'h4);
    repeat (2) @(posedge clk);
    chk({31'h0, stage_active}, 32'h1);
    $display("register test done");
endtask
task automatic t_trq;
    i_dsmc_src_model.set_src(16'd1000, 16'd0);
    wb(1, DSMC_ADR_SRC, 32'h1);
    wb(1, DSMC_ADR_AN_SCL, 32'h0000_0200);
    wb(1, DSMC_ADR_CTRL, 32'h1);
    wb(1, DSMC_ADR_MODE, {24'h0, DSMC_MODE_TRQ});
    wup(2);
    chk(ctl_setpoint, 32'd500);
    chk({29'h0, ctl_mode}, 32'h4);
    i_dsmc_src_model.set_src(16'd2000, 16'd0);
    wup(2);
    chk(ctl_setpoint, {16'h0, DSMC_RATED_CUR});
    $display("torque test done");
endtask
task automatic t_spd;
    i_dsmc_src_model.set_src(16'd0, 16'd300);
    actual_rpm <= 16'd20;
    wb(1, DSMC_ADR_SRC, 32'h30);
    wb(1, DSMC_ADR_PWM_SCL, 32'h0000_0400);
    wb(1, DSMC_ADR_MODE, {24'h0, DSMC_MODE_SPD});
    wup(2);
    chk(ctl_setpoint, 32'd300);
    chk({29'h0, ctl_mode}, 32'h2);
    actual_rpm <= 16'd1400;
    repeat (3) @(posedge clk);
    wb(0, DSMC_ADR_STAT, 0);
    chk(q, 32'h0000_0064);
    $display("speed test done");
endtask
task automatic t_pos;
    wb(1, DSMC_ADR_SRC, 32'h900);
    wb(1, DSMC_ADR_RENC, 32'h0000_0800);
    wb(1, DSMC_ADR_MODE, {24'h0, DSMC_MODE_POS});
    wup(2);
    chk(ctl_setpoint, 32'd0);
    i_dsmc_src_model.pulses(5, 1'b0);
    wup(2);
    chk(ctl_setpoint, 32'd10);
    chk({29'h0, ctl_mode}, 32'h1);
    $display("position test done");
endtask
task automatic t_irq;
    wb(1, DSMC_ADR_IRQ_MSK, 32'h7);
    wb(1, DSMC_ADR_IRQ_ST, 32'h7);
    wb(1, DSMC_ADR_MODE, {24'h0, DSMC_MODE_TRQ});
    repeat (3) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    // a set mask bit lets its status bit through
    wb(1, DSMC_ADR_IRQ_MSK, 32'h6);
    repeat (3) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    wb(1, DSMC_ADR_IRQ_ST, 32'h1);
    wb(1, DSMC_ADR_IRQ_MSK, 32'h7);
    repeat (3) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    {lim_pos_sw, lim_neg_sw} <= 2'b11;
    repeat (10) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    wb(0, DSMC_ADR_IRQ_ST, 0);
    chk(q & 32'h4, 32'h4);
    $display("interrupt test done");
endtask
task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
        $display("All checks passed");
    end else begin
        $display("Checks failed");
    end
    $finish;
endtask
initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_regs;
    t_trq;
    t_spd;
    t_pos;
    t_irq;
    stop_test;
end
initial begin
    repeat (40000) @(posedge clk);
    bad_count++;
    stop_test;
end
endmodule
`default_nettype wire

// File: design/dsmc_pkg.sv
/*
 * dsmc_pkg: constants, register offsets and types of the discrete set-point
 * mode control block.
 * Assumes a 10 MHz system clock and a classic Wishbone register slave.
 */
package dsmc_pkg;
    // operation mode codes, two's complement in eight bits
    localparam logic [7:0] DSMC_MODE_POS = 8'hfe;
    localparam logic [7:0] DSMC_MODE_SPD = 8'hfd;
    localparam logic [7:0] DSMC_MODE_TRQ = 8'hfc;

    // source selector codes
    localparam logic [3:0] DSMC_SRC_NONE = 4'h0;
    localparam logic [3:0] DSMC_SRC_AN1  = 4'h1;
    localparam logic [3:0] DSMC_SRC_AN2  = 4'h2;
    localparam logic [3:0] DSMC_SRC_PWM  = 4'h3;
    localparam logic [3:0] DSMC_SRC_MENC = 4'h4;
    localparam logic [3:0] DSMC_SRC_ABS  = 4'h5;
    localparam logic [3:0] DSMC_SRC_REF  = 4'h9;

    // register byte addresses
    localparam logic [7:0] DSMC_ADR_MODE    = 8'h00;
    localparam logic [7:0] DSMC_ADR_SRC     = 8'h04;
    localparam logic [7:0] DSMC_ADR_OPTS    = 8'h08;
    localparam logic [7:0] DSMC_ADR_AN_SCL  = 8'h0c;
    localparam logic [7:0] DSMC_ADR_PWM_SCL = 8'h10;
    localparam logic [7:0] DSMC_ADR_MENC    = 8'h14;
    localparam logic [7:0] DSMC_ADR_RENC    = 8'h18;
    localparam logic [7:0] DSMC_ADR_SETPT   = 8'h1c;
    localparam logic [7:0] DSMC_ADR_STAT    = 8'h20;
    localparam logic [7:0] DSMC_ADR_IRQ_ST  = 8'h24;
    localparam logic [7:0] DSMC_ADR_IRQ_MSK = 8'h28;
    localparam logic [7:0] DSMC_ADR_CTRL    = 8'h2c;

    // field positions
    localparam int DSMC_SRC_TRQ_LSB  = 0;
    localparam int DSMC_SRC_SPD_LSB  = 4;
    localparam int DSMC_SRC_POS_LSB  = 8;
    localparam int DSMC_OPT_AUTO_BIT = 2;
    localparam int DSMC_ABS_BITS_LSB = 16;

    // reset values
    localparam logic [7:0]  DSMC_RST_MODE = 8'h00;
    localparam logic [11:0] DSMC_RST_SRC  = 12'h000;
    localparam logic [31:0] DSMC_RST_SCL  = 32'h0400_0000;
    localparam logic [31:0] DSMC_RST_ENC  = 32'h0000_1000;

    // scaling: gain is q6.10 fixed point, 1.0 = 0x400
    localparam int DSMC_GAIN_FRAC = 10;
    // rated current in set-point units
    localparam logic [15:0] DSMC_RATED_CUR = 16'h03e8;

    // control cycle: 100 us at 10 MHz
    localparam int DSMC_CLK_HZ      = 10_000_000;
    localparam int DSMC_CYCLE_US    = 100;
    localparam int DSMC_CYCLE_CLKS  = DSMC_CLK_HZ / 1_000_000 * DSMC_CYCLE_US;
    localparam int DSMC_CYCLES_MIN  = 10_000;
    // speed window: 10 ms of control cycles, rpm = cnt*6000/res
    localparam int DSMC_SPD_WIN     = 100;
    localparam logic [31:0] DSMC_RPM_NUM = 32'h0000_1770;

    // interrupt status bits
    localparam int DSMC_EV_MODE  = 0;
    localparam int DSMC_EV_SLIP  = 1;
    localparam int DSMC_EV_LIMIT = 2;
    localparam int DSMC_EV_W     = 3;

    typedef enum logic [3:0] {
        DSMC_ST_IDLE = 4'b0001,
        DSMC_ST_POS  = 4'b0010,
        DSMC_ST_SPD  = 4'b0100,
        DSMC_ST_TRQ  = 4'b1000
    } dsmc_state_t;
endpackage

// File: design/dsmc_top.sv
/*
 * dsmc_top: discrete set-point mode control. Picks a set-point source per
 * mode, scales it and hands it to the control loops once per control cycle.
 * Assumes synchronous sample inputs from the converters, asynchronous
 * encoder and digital pins, and a classic Wishbone master.
 */
`timescale 1ns/100ps
`default_nettype none
module dsmc_top
    import dsmc_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // raw set-point samples, same clock
    input  wire logic [15:0] analog_input_one,
    input  wire logic [15:0] analog_input_two,
    input  wire logic [15:0] pwm_duty,
    input  wire logic [31:0] abs_enc_pos,
    // asynchronous pins
    input  wire logic        menc_a,
    input  wire logic        menc_b,
    input  wire logic        renc_a,
    input  wire logic        renc_b,
    input  wire logic        digital_input_one,
    input  wire logic        digital_input_two,
    input  wire logic        lim_pos_sw,
    input  wire logic        lim_neg_sw,
    // feedback and controller side
    input  wire logic [31:0] actual_pos,
    input  wire logic [15:0] actual_rpm,
    output logic      [31:0] ctl_setpoint,
    output logic      [2:0]  ctl_mode,
    output logic             ctl_update,
    output logic             stage_active,
    output logic             irq
);

    // synchronisers: three flops, a change counts when stages two and three agree
    logic [7:0] s1_ff, s2_ff, s3_ff, pin_ff;
    wire  [7:0] pins_raw = {lim_neg_sw, lim_pos_sw, digital_input_two, digital_input_one,
                            renc_b, renc_a, menc_b, menc_a};
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_sync
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    s1_ff[gi]  <= 1'b0;
                    s2_ff[gi]  <= 1'b0;
                    s3_ff[gi]  <= 1'b0;
                    pin_ff[gi] <= 1'b0;
                end else begin
                    s1_ff[gi] <= pins_raw[gi];
                    s2_ff[gi] <= s1_ff[gi];
                    s3_ff[gi] <= s2_ff[gi];
                    if (s2_ff[gi] == s3_ff[gi])
                        pin_ff[gi] <= s3_ff[gi];
                end
            end
        end
    endgenerate

    // registers
    logic [7:0]  mode_ff;
    logic [11:0] src_ff;
    logic [7:0]  opts_ff;
    logic [31:0] an_scl_ff, pwm_scl_ff, menc_ff, renc_ff;
    logic [15:0] setpt_ff;
    logic [31:0] lim_lo_ff, lim_hi_ff;
    logic [DSMC_EV_W-1:0] irq_st_ff, irq_msk_ff, ev;
    logic        enable_ff, slip_ff, limit_ff;
    dsmc_state_t state_ff;

    wire wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire wb_wr  = wb_req && wb_we_i;

    function automatic logic [31:0] bmerge(input logic [31:0] old, input logic [31:0] nw,
                                           input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++)
            if (sel[b])
                r[b*8 +: 8] = nw[b*8 +: 8];
        return r;
    endfunction

    logic [31:0] nxt_w;
    always_comb begin
        nxt_w = 32'h0;
        case (wb_adr_i)
            DSMC_ADR_MODE:    nxt_w = bmerge({24'h0, mode_ff}, wb_dat_i, wb_sel_i);
            DSMC_ADR_SRC:     nxt_w = bmerge({20'h0, src_ff}, wb_dat_i, wb_sel_i);
            DSMC_ADR_OPTS:    nxt_w = bmerge({24'h0, opts_ff}, wb_dat_i, wb_sel_i);
            DSMC_ADR_AN_SCL:  nxt_w = bmerge(an_scl_ff, wb_dat_i, wb_sel_i);
            DSMC_ADR_PWM_SCL: nxt_w = bmerge(pwm_scl_ff, wb_dat_i, wb_sel_i);
            DSMC_ADR_MENC:    nxt_w = bmerge(menc_ff, wb_dat_i, wb_sel_i);
            DSMC_ADR_RENC:    nxt_w = bmerge(renc_ff, wb_dat_i, wb_sel_i);
            DSMC_ADR_SETPT:   nxt_w = bmerge({16'h0, setpt_ff}, wb_dat_i, wb_sel_i);
            DSMC_ADR_IRQ_MSK: nxt_w = bmerge({29'h0, irq_msk_ff}, wb_dat_i, wb_sel_i);
            DSMC_ADR_CTRL:    nxt_w = bmerge({31'h0, enable_ff}, wb_dat_i, wb_sel_i);
            default:          nxt_w = wb_dat_i;
        endcase
    end

    // configuration registers; the soft limits are constants, not registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_ff    <= DSMC_RST_MODE;
            src_ff     <= DSMC_RST_SRC;
            opts_ff    <= 8'h00;
            an_scl_ff  <= DSMC_RST_SCL;
            pwm_scl_ff <= DSMC_RST_SCL;
            menc_ff    <= DSMC_RST_ENC;
            renc_ff    <= DSMC_RST_ENC;
            setpt_ff   <= 16'h0;
            irq_msk_ff <= '0;
        end else if (wb_wr) begin
            case (wb_adr_i)
                DSMC_ADR_MODE:    mode_ff    <= nxt_w[7:0];
                DSMC_ADR_SRC:     src_ff     <= nxt_w[11:0];
                DSMC_ADR_OPTS:    opts_ff    <= nxt_w[7:0];
                DSMC_ADR_AN_SCL:  an_scl_ff  <= nxt_w;
                DSMC_ADR_PWM_SCL: pwm_scl_ff <= nxt_w;
                DSMC_ADR_MENC:    menc_ff    <= nxt_w;
                DSMC_ADR_RENC:    renc_ff    <= nxt_w;
                DSMC_ADR_SETPT:   setpt_ff   <= nxt_w[15:0];
                DSMC_ADR_IRQ_MSK: irq_msk_ff <= nxt_w[DSMC_EV_W-1:0];
                default:          ;
            endcase
        end
    end

    // soft position limits are fixed full range; only the switches bound travel
    assign lim_lo_ff = 32'h8000_0000;
    assign lim_hi_ff = 32'h7fff_ffff;

    // output stage enable: software bit, or auto-start option
    // options reset to zero, so auto-start stays armed until software owns the enable
    logic started_ff;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            enable_ff  <= 1'b0;
            started_ff <= 1'b0;
        end else if (wb_wr && wb_adr_i == DSMC_ADR_CTRL) begin
            enable_ff  <= nxt_w[0];
            started_ff <= 1'b1;
        end else if (!started_ff && opts_ff[DSMC_OPT_AUTO_BIT]) begin
            enable_ff  <= 1'b1;
            started_ff <= 1'b1;
        end
    end
    assign stage_active = enable_ff;

    // control cycle tick
    logic [$clog2(DSMC_CYCLE_CLKS)-1:0] div_ff;
    wire tick = (div_ff == ($clog2(DSMC_CYCLE_CLKS))'(DSMC_CYCLE_CLKS - 1));
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            div_ff <= '0;
        else if (tick)
            div_ff <= '0;
        else
            div_ff <= div_ff + 1'b1;
    end

    // mode decode
    dsmc_state_t nxt_state;
    always_comb begin
        case (mode_ff)
            DSMC_MODE_POS: nxt_state = DSMC_ST_POS;
            DSMC_MODE_SPD: nxt_state = DSMC_ST_SPD;
            DSMC_MODE_TRQ: nxt_state = DSMC_ST_TRQ;
            default:       nxt_state = DSMC_ST_IDLE;
        endcase
    end
    wire mode_chg = (nxt_state != state_ff);

    // latched selection and scaling at each mode change
    logic [3:0]  sel_ff;
    logic [31:0] gain_scl_ff, res_ff;
    logic [31:0] base_ff;
    logic [3:0]  nxt_sel;
    always_comb begin
        case (nxt_state)
            DSMC_ST_POS: nxt_sel = src_ff[DSMC_SRC_POS_LSB +: 4];
            DSMC_ST_SPD: nxt_sel = src_ff[DSMC_SRC_SPD_LSB +: 4];
            DSMC_ST_TRQ: nxt_sel = src_ff[DSMC_SRC_TRQ_LSB +: 4];
            default:     nxt_sel = DSMC_SRC_NONE;
        endcase
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff    <= DSMC_ST_IDLE;
            sel_ff      <= DSMC_SRC_NONE;
            gain_scl_ff <= DSMC_RST_SCL;
            res_ff      <= DSMC_RST_ENC;
            base_ff     <= 32'h0;
        end else if (mode_chg) begin
            state_ff    <= nxt_state;
            sel_ff      <= nxt_sel;
            gain_scl_ff <= (nxt_sel == DSMC_SRC_PWM) ? pwm_scl_ff : an_scl_ff;
            res_ff      <= (nxt_sel == DSMC_SRC_REF) ? renc_ff : menc_ff;
            base_ff     <= actual_pos;
        end
    end

    // quadrature decoders, motor encoder and reference/pulse input
    logic [31:0] mcnt_ff, rcnt_ff, mprev_ab_ff, rprev_ab_ff;
    function automatic logic [31:0] qstep(input logic [1:0] o, input logic [1:0] n);
        case ({o, n})
            4'b0001, 4'b0111, 4'b1110, 4'b1000: qstep = 32'h0000_0001;
            4'b0010, 4'b1011, 4'b1101, 4'b0100: qstep = 32'hffff_ffff;
            default:                            qstep = 32'h0;
        endcase
    endfunction
    wire step_rise = pin_ff[4] && !rprev_ab_ff[2];
    wire pulse_mode = (sel_ff == DSMC_SRC_REF) && (state_ff == DSMC_ST_POS);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mcnt_ff     <= 32'h0;
            rcnt_ff     <= 32'h0;
            mprev_ab_ff <= 32'h0;
            rprev_ab_ff <= 32'h0;
        end else begin
            mprev_ab_ff <= {30'h0, pin_ff[1:0]};
            rprev_ab_ff <= {29'h0, pin_ff[4], pin_ff[3:2]};
            if (mode_chg) begin
                mcnt_ff <= 32'h0;
                rcnt_ff <= 32'h0;
            end else begin
                mcnt_ff <= mcnt_ff + qstep(mprev_ab_ff[1:0], pin_ff[1:0]);
                if (pulse_mode && step_rise)
                    rcnt_ff <= pin_ff[5] ? rcnt_ff - 1'b1 : rcnt_ff + 1'b1;
                else if (!pulse_mode)
                    rcnt_ff <= rcnt_ff + qstep(rprev_ab_ff[1:0], pin_ff[3:2]);
            end
        end
    end

    // speed window: counts over DSMC_SPD_WIN control cycles
    logic [6:0]  win_ff;
    logic [31:0] wstart_ff, wdelta_ff, abs_prev_ff;
    wire [31:0] cnt_now = (sel_ff == DSMC_SRC_REF) ? rcnt_ff : mcnt_ff;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            win_ff      <= 7'h0;
            wstart_ff   <= 32'h0;
            wdelta_ff   <= 32'h0;
            abs_prev_ff <= 32'h0;
        end else if (tick) begin
            if (win_ff == 7'(DSMC_SPD_WIN - 1)) begin
                win_ff      <= 7'h0;
                wstart_ff   <= cnt_now;
                abs_prev_ff <= abs_enc_pos;
                wdelta_ff   <= (sel_ff == DSMC_SRC_ABS) ? abs_enc_pos - abs_prev_ff
                                                        : cnt_now - wstart_ff;
            end else begin
                win_ff <= win_ff + 1'b1;
            end
        end
    end

    // scaling
    function automatic logic [31:0] scale(input logic [15:0] raw, input logic [31:0] scl);
        logic signed [47:0] p;
        p = 48'(signed'({1'b0, raw}) + signed'(scl[31:16])) * 48'(signed'(scl[15:0]));
        return 32'(p >>> DSMC_GAIN_FRAC);
    endfunction
    logic [31:0] rpm_div;
    logic [5:0]  abs_bits;
    logic [31:0] nxt_sp;
    always_comb begin
        abs_bits = res_ff[DSMC_ABS_BITS_LSB +: 6];
        rpm_div  = (sel_ff == DSMC_SRC_ABS) ? (32'h1 << abs_bits) : res_ff;
        if (rpm_div == 32'h0)
            rpm_div = 32'h1;
        case (sel_ff)
            DSMC_SRC_AN1: nxt_sp = scale(analog_input_one, gain_scl_ff);
            DSMC_SRC_AN2: nxt_sp = scale(analog_input_two, gain_scl_ff);
            DSMC_SRC_PWM: nxt_sp = scale(pwm_duty, gain_scl_ff);
            DSMC_SRC_MENC, DSMC_SRC_REF, DSMC_SRC_ABS:
                if (state_ff == DSMC_ST_SPD)
                    nxt_sp = 32'(64'(signed'(wdelta_ff)) * 64'(signed'(DSMC_RPM_NUM))
                                 / 64'(signed'({1'b0, rpm_div})));
                else if (sel_ff == DSMC_SRC_REF)
                    nxt_sp = base_ff + 32'(64'(signed'(rcnt_ff)) * 64'(signed'(renc_ff))
                                           >>> DSMC_GAIN_FRAC);
                else
                    nxt_sp = base_ff + mcnt_ff;
            default:      nxt_sp = {{16{setpt_ff[15]}}, setpt_ff};
        endcase
    end

    // per-cycle application, straight through with no ramp
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctl_setpoint <= 32'h0;
            ctl_mode     <= 3'h0;
            ctl_update   <= 1'b0;
        end else begin
            ctl_update <= 1'b0;
            if (tick && enable_ff && state_ff != DSMC_ST_IDLE) begin
                ctl_setpoint <= nxt_sp;
                ctl_mode     <= state_ff[3:1];
                ctl_update   <= 1'b1;
            end
        end
    end

    // monitors: slippage in speed mode, switches in every mode but idle
    wire [31:0] err = ctl_setpoint - {16'h0, actual_rpm};
    wire sw_hit = (pin_ff[6] || pin_ff[7]) && state_ff != DSMC_ST_IDLE;
    wire pos_hit = (state_ff == DSMC_ST_POS) && ($signed(actual_pos) < $signed(lim_lo_ff)
                   || $signed(actual_pos) > $signed(lim_hi_ff));
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            slip_ff  <= 1'b0;
            limit_ff <= 1'b0;
        end else begin
            slip_ff  <= (state_ff == DSMC_ST_SPD) && enable_ff
                        && ($signed(err) > $signed({16'h0, DSMC_RATED_CUR})
                        || $signed(err) < -$signed({16'h0, DSMC_RATED_CUR}));
            limit_ff <= sw_hit || pos_hit;
        end
    end

    // interrupts: set wins over write-one-to-clear
    assign ev = {limit_ff, slip_ff, mode_chg};
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            irq_st_ff <= '0;
        else if (wb_wr && wb_adr_i == DSMC_ADR_IRQ_ST)
            irq_st_ff <= (irq_st_ff & ~wb_dat_i[DSMC_EV_W-1:0]) | ev;
        else
            irq_st_ff <= irq_st_ff | ev;
    end
    assign irq = |(irq_st_ff & irq_msk_ff);

    // bus answer: one wait state, unmapped reads give zero; status word fixed
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            wb_ack_o <= wb_req;
            if (wb_req) begin
                case (wb_adr_i)
                    DSMC_ADR_MODE:    wb_dat_o <= {24'h0, mode_ff};
                    DSMC_ADR_SRC:     wb_dat_o <= {20'h0, src_ff};
                    DSMC_ADR_OPTS:    wb_dat_o <= {24'h0, opts_ff};
                    DSMC_ADR_AN_SCL:  wb_dat_o <= an_scl_ff;
                    DSMC_ADR_PWM_SCL: wb_dat_o <= pwm_scl_ff;
                    DSMC_ADR_MENC:    wb_dat_o <= menc_ff;
                    DSMC_ADR_RENC:    wb_dat_o <= renc_ff;
                    DSMC_ADR_SETPT:   wb_dat_o <= ctl_setpoint;
                    DSMC_ADR_STAT:    wb_dat_o <= {24'h0, limit_ff, slip_ff, enable_ff,
                                                   1'b0, state_ff};
                    DSMC_ADR_IRQ_ST:  wb_dat_o <= {29'h0, irq_st_ff};
                    DSMC_ADR_IRQ_MSK: wb_dat_o <= {29'h0, irq_msk_ff};
                    DSMC_ADR_CTRL:    wb_dat_o <= {31'h0, enable_ff};
                    default:          wb_dat_o <= 32'h0;
                endcase
            end
        end
    end

    AST_MODE_POS: assert property (@(posedge clk) disable iff (!rst_n)
        (mode_ff == DSMC_MODE_POS) |=> (state_ff == DSMC_ST_POS))
        else $error("position mode not entered");
    AST_MODE_SPD: assert property (@(posedge clk) disable iff (!rst_n)
        (mode_ff == DSMC_MODE_SPD) |=> (state_ff == DSMC_ST_SPD))
        else $error("speed mode not entered");
    AST_MODE_TRQ: assert property (@(posedge clk) disable iff (!rst_n)
        (mode_ff == DSMC_MODE_TRQ) |=> (state_ff == DSMC_ST_TRQ))
        else $error("torque mode not entered");
    AST_PASS: assert property (@(posedge clk) disable iff (!rst_n)
        (tick && enable_ff && state_ff != DSMC_ST_IDLE) |=> ctl_update
        && ctl_setpoint == $past(nxt_sp))
        else $error("set-point not applied at once");
    AST_NO_UPD_OFF: assert property (@(posedge clk) disable iff (!rst_n)
        !$past(enable_ff) |-> !ctl_update)
        else $error("update with stage off");
    AST_AUTO: assert property (@(posedge clk) disable iff (!rst_n)
        (!started_ff && opts_ff[DSMC_OPT_AUTO_BIT] && !(wb_wr && wb_adr_i == DSMC_ADR_CTRL))
        |=> enable_ff)
        else $error("auto start missing");
    AST_LATCH: assert property (@(posedge clk) disable iff (!rst_n)
        mode_chg |=> sel_ff == $past(nxt_sel))
        else $error("source not latched");
    AST_RELCNT: assert property (@(posedge clk) disable iff (!rst_n)
        mode_chg |=> mcnt_ff == 32'h0 && rcnt_ff == 32'h0)
        else $error("counters not cleared at mode change");
    AST_IRQ: assert property (@(posedge clk) disable iff (!rst_n)
        (irq_st_ff[DSMC_EV_MODE] && irq_msk_ff[DSMC_EV_MODE]) |-> irq)
        else $error("irq not raised");
endmodule
`default_nettype wire
